// File: pkg/pkt_arb_consts.svh
// Register map, field positions and timing counts of the packet RAM arbiter
// Assumes a 100 MHz clock; offsets are byte addresses on a 32-bit bus
`ifndef PKT_ARB_CONSTS_SVH
`define PKT_ARB_CONSTS_SVH

// Register byte offsets
`define REG_CTRL     8'h00
`define REG_STATUS   8'h04
`define REG_MMU_CMD  8'h08
`define REG_PNS      8'h0C
`define REG_ALLOC    8'h10
`define REG_QPORT    8'h14
`define REG_PTR      8'h18
`define REG_DATA     8'h1C
`define REG_DATAB    8'h20
`define REG_RESERVE  8'h24
`define REG_FREE     8'h28

// Control fields
`define CTRL_AUTO_REL 0
`define CTRL_RX_EN    1

// Status fields
`define ST_RX        0
`define ST_TXDONE    1
`define ST_TXEMPTY   2
`define ST_ALLOC     3
`define ST_BUSY      4
`define ST_HALT      5

// Other fields
`define CMD_BUSY     0
`define ALLOC_DONE   31
`define QP_CEMPTY    15
`define QP_RXPN      16
`define QP_REMPTY    31

// Memory manager command codes
`define CMD_ALLOC    3'h1
`define CMD_RELEASE  3'h2
`define CMD_ENQUEUE  3'h3
`define CMD_RX_REM   3'h4
`define CMD_TX_ACK   3'h5

// Bus responses and reset value
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`define RESET_WORD   32'h0000_0000

// Data register timing
`define CLK_NS       10
`define ACCESS_NS    40
`define CYCLE_NS     185
`define ACCESS_CYC   ((`ACCESS_NS) / (`CLK_NS))
`define CYCLE_CYC    (((`CYCLE_NS) + (`CLK_NS) - 1) / (`CLK_NS))

`endif

// File: pkg/pkt_arb_pkg.sv
// Types shared by the packet RAM arbiter and its users
// Assumes nothing of its surroundings
package pkt_arb_pkg;
  // Requests the transmit/receive engine may post
  typedef enum logic [2:0] {
    DOP_ALLOC, DOP_RELEASE, DOP_READ, DOP_WRITE, DOP_TXOK, DOP_TXFAIL, DOP_RXDONE
  } dma_op_e;
endpackage

// File: verilog/pkt_ram.sv
// Single-ported byte-wide packet RAM with registered read data
// Assumes one access per clock, issued by the arbiter
`timescale 1ns/1ps
`default_nettype none
module pkt_ram #(
  parameter int AW = 11
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output var  logic [7:0]    q
);
  logic [7:0] mem [2**AW];

  // Refuse address widths the array cannot sensibly hold
  if (AW < 1 || AW > 20) begin : g_bad
    $error("unsupported packet memory address width");
  end

  // Read-before-write; contents are not reset
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    q <= mem[addr];
  end
endmodule // pkt_ram
`default_nettype wire

// File: verilog/packet_ram_arbiter_mmu_irq.sv
// Packet RAM arbiter, memory manager and packet queues with AXI4-Lite registers
// Assumes a transmit/receive engine holding dma_req until dma_ack
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`include "pkt_arb_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module packet_ram_arbiter_mmu_irq import pkt_arb_pkg::*; #(
  parameter int NP   = 8,
  parameter int PAGE = 256
) (
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic [7:0]         awaddr,
  input  wire logic               awvalid,
  output var  logic               awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output var  logic               wready,
  output var  logic [1:0]         bresp,
  output var  logic               bvalid,
  input  wire logic               bready,
  input  wire logic [7:0]         araddr,
  input  wire logic               arvalid,
  output var  logic               arready,
  output var  logic [31:0]        rdata,
  output var  logic [1:0]         rresp,
  output var  logic               rvalid,
  input  wire logic               rready,
  input  wire logic               dma_req,
  input  wire dma_op_e            dma_op,
  input  wire logic [$clog2(NP)-1:0]   dma_pn,
  input  wire logic [$clog2(PAGE)-1:0] dma_off,
  input  wire logic [7:0]         dma_wdata,
  output var  logic               dma_ack,
  output var  logic               dma_ok,
  output var  logic [$clog2(NP)-1:0]   dma_result_pn,
  output var  logic [7:0]         dma_rdata,
  output var  logic               tx_head_valid,
  output var  logic [$clog2(NP)-1:0]   tx_head_pn
);
  localparam int PW  = $clog2(NP);
  localparam int OW  = $clog2(PAGE);
  localparam int ACC = `ACCESS_CYC;

  // Refuse shapes the field layout cannot hold
  if (NP < 2 || NP > 64 || (1 << PW) != NP || PAGE < 4 || (1 << OW) != PAGE ||
      PW + OW > 20) begin : g_bad
    $error("unsupported packet count or page size");
  end

  typedef logic [NP-1:0][PW-1:0] q_t;
  typedef logic [3:0][7:0]       bf_t;
  typedef struct packed {
    logic          awready, wready, bvalid, arready, rvalid;
    logic [1:0]    bresp, rresp;
    logic [31:0]   rdata;
    logic          auto_rel, rx_en, tx_halt;
    logic          alloc_done, alloc_pend, busy, rel_pend;
    logic [PW-1:0] rel_pn, alloc_pn, pns;
    logic [OW-1:0] ptr, fptr;
    logic [PW:0]   reserve;
    logic [NP-1:0] used;
    q_t            txq, cq, rxq;
    logic [PW:0]   txn, cn, rxn;
    bf_t           wf, rf;
    logic [2:0]    wn, rn;
    logic          rd_mode, rd_fly, dma_fly, last_dma;
    logic          dma_ack, dma_ok, tx_hv;
    logic [PW-1:0] dma_res, tx_hpn;
    logic [7:0]    dma_rdata;
  } st_s;

  st_s s;
  st_s next_s;

  // Physical address from packet number and offset alone
  function automatic logic [PW+OW-1:0] maddr(input logic [PW-1:0] pn,
                                             input logic [OW-1:0] off);
    return {pn, off};
  endfunction

  // Queue as deep as the packet count, so it cannot overflow
  function automatic q_t qnext(input q_t q, input logic [PW:0] c, input logic pop,
                               input logic push, input logic [PW-1:0] v);
    q_t r;
    r = pop ? (q >> PW) : q;
    if (push) begin
      r[PW'(c - (PW+1)'(pop))] = v;
    end
    return r;
  endfunction

  // Byte FIFO: pop bytes at the head, append one or two bytes
  function automatic bf_t bnext(input bf_t q, input logic [2:0] c, input logic [2:0] popk,
                                input logic [2:0] pushk, input logic [15:0] v);
    bf_t        r;
    logic [2:0] b;
    r = q >> {popk, 3'b000};
    b = c - popk;
    for (int i = 0; i < 2; i++) begin
      if (3'(i) < pushk) begin
        r[2'(b + 3'(i))] = v[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [PW:0] nfree(input logic [NP-1:0] u);
    logic [PW:0] c;
    c = '0;
    for (int i = 0; i < NP; i++) begin
      c = c + (PW+1)'(!u[i]);
    end
    return c;
  endfunction

  function automatic logic [PW-1:0] first_free(input logic [NP-1:0] u);
    logic [PW-1:0] p;
    p = '0;
    for (int i = NP - 1; i >= 0; i--) begin
      if (!u[i]) begin
        p = PW'(i);
      end
    end
    return p;
  endfunction

  logic [PW:0]       free_cnt;
  logic [PW-1:0]     pick;
  logic              have_free, rd_room, host_want, dma_want, grant_dma, grant_host;
  logic              h_rel, h_wr, h_al, h_rd;
  logic              mem_we;
  logic [PW+OW-1:0]  mem_addr;
  logic [7:0]        mem_wdata, mem_q;
  logic [2:0]        wr_k, rd_k;
  logic              is_wdat, is_rdat, wr_ok, rd_ok, wstep, rstep;
  logic [31:0]       status_word;
  logic [PW-1:0]     head_pn;

  assign free_cnt  = nfree(s.used);
  assign pick      = first_free(s.used);
  assign have_free = free_cnt != '0;
  assign head_pn   = s.txq[0];
  assign rd_room   = (4'(s.rn) + 4'(s.rd_fly)) < 4'd4;

  // One RAM slot per cycle, engine and host alternate under contention
  assign host_want  = s.rel_pend | (s.wn != '0) | s.alloc_pend | (s.rd_mode & rd_room);
  assign dma_want   = dma_req & ~s.dma_fly & ~s.dma_ack;
  assign grant_dma  = dma_want & (~host_want | ~s.last_dma);
  assign grant_host = host_want & ~grant_dma;

  // Host priority: release, write-behind, allocation, prefetch
  assign h_rel = grant_host & s.rel_pend;
  assign h_wr  = grant_host & ~s.rel_pend & (s.wn != '0);
  assign h_al  = grant_host & ~s.rel_pend & (s.wn == '0) & s.alloc_pend;
  assign h_rd  = grant_host & ~s.rel_pend & (s.wn == '0) & ~s.alloc_pend;

  // Engine address for the engine, pointers for the host
  assign mem_we    = h_wr | (grant_dma & (dma_op == DOP_WRITE));
  assign mem_addr  = grant_dma ? maddr(dma_pn, dma_off)
                   : maddr(s.pns, h_wr ? s.ptr : s.fptr);
  assign mem_wdata = grant_dma ? dma_wdata : s.wf[0];

  pkt_ram #(.AW(PW + OW)) u_ram (
    .clk   (clk),
    .we    (mem_we),
    .addr  (mem_addr),
    .wdata (mem_wdata),
    .q     (mem_q)
  );

  // Bus access acceptance; data accesses wait on FIFO room or fill
  // Pointer loads also wait while a prefetch is issued, so no stale byte follows the flush
  assign is_wdat = (awaddr == `REG_DATA) | (awaddr == `REG_DATAB);
  assign is_rdat = (araddr == `REG_DATA) | (araddr == `REG_DATAB);
  assign wr_k    = ((awaddr == `REG_DATA) && wstrb[1]) ? 3'd2 : 3'd1;
  assign rd_k    = (araddr == `REG_DATA) ? 3'd2 : 3'd1;
  assign wr_ok   = is_wdat ? (s.wn + wr_k <= 3'd4)
                 : (awaddr == `REG_PTR) ? ((s.wn == '0) & ~s.rd_fly & ~h_rd) : 1'b1;
  assign rd_ok   = is_rdat ? (~s.rd_mode | (s.rn >= rd_k)) : 1'b1;
  assign wstep   = ~s.awready & ~s.bvalid & awvalid & wvalid & wr_ok;
  assign rstep   = ~s.arready & ~s.rvalid & arvalid & rd_ok;

  // Status flags follow the queues and the manager flags directly; the receive flag is gated by rx_en
  always_comb begin
    status_word              = `RESET_WORD;
    status_word[`ST_RX]      = (s.rxn != '0) & s.rx_en;
    status_word[`ST_TXDONE]  = s.cn != '0;
    status_word[`ST_TXEMPTY] = s.txn == '0;
    status_word[`ST_ALLOC]   = s.alloc_done;
    status_word[`ST_BUSY]    = s.busy;
    status_word[`ST_HALT]    = s.tx_halt;
  end

  // Next state: arbitration grants first, then bus accesses
  always_comb begin
    logic          t_push, t_pop, c_push, c_pop, r_push, r_pop;
    logic [PW-1:0] t_v, c_v, r_v;
    logic [2:0]    wpush, rpop;
    logic [31:0]   rv;
    t_push = 1'b0; t_pop = 1'b0; c_push = 1'b0; c_pop = 1'b0; r_push = 1'b0; r_pop = 1'b0;
    t_v = s.pns; c_v = head_pn; r_v = dma_pn;
    wpush = 3'd0; rpop = 3'd0; rv = `RESET_WORD;
    next_s = s;
    next_s.dma_ack = 1'b0;
    next_s.rd_fly  = h_rd;
    next_s.dma_fly = grant_dma & (dma_op == DOP_READ);
    if (grant_dma | grant_host) begin
      next_s.last_dma = grant_dma;
    end
    // Host memory manager and RAM work
    if (h_rel) begin
      next_s.used[s.rel_pn] = 1'b0;
      next_s.rel_pend = 1'b0;
      next_s.busy = 1'b0;
    end
    if (h_wr) begin
      next_s.ptr = s.ptr + 1'b1;
    end
    if (h_al && have_free) begin
      next_s.used[pick]  = 1'b1;
      next_s.alloc_pn    = pick;
      next_s.alloc_done  = 1'b1;
      next_s.alloc_pend  = 1'b0;
    end
    if (h_rd) begin
      next_s.fptr = s.fptr + 1'b1;
    end
    // Read data returns one cycle after the RAM slot
    if (s.dma_fly) begin
      next_s.dma_ack   = 1'b1;
      next_s.dma_ok    = 1'b1;
      next_s.dma_rdata = mem_q;
    end
    // Engine requests; results go to memory and queues, no host read needed
    if (grant_dma && dma_op != DOP_READ) begin
      next_s.dma_ack = 1'b1;
      next_s.dma_ok  = 1'b1;
      unique case (dma_op)
        DOP_ALLOC: begin
          if (have_free && free_cnt >= s.reserve) begin
            next_s.used[pick] = 1'b1;
            next_s.dma_res = pick;
          end else begin
            next_s.dma_ok = 1'b0;
          end
        end
        DOP_RELEASE: next_s.used[dma_pn] = 1'b0;
        DOP_TXOK: begin
          t_pop = s.txn != '0;
          if (s.auto_rel) begin
            next_s.used[head_pn] = 1'b0;
          end else begin
            c_push = s.txn != '0;
          end
        end
        DOP_TXFAIL: begin
          c_push = 1'b1;
          next_s.tx_halt = 1'b1;
        end
        DOP_RXDONE: r_push = 1'b1;
        default: next_s.dma_ok = 1'b1;
      endcase
    end
    // Write channel
    if (s.awready) begin
      next_s.awready = 1'b0;
      next_s.wready  = 1'b0;
      next_s.bvalid  = 1'b1;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (wstep) begin
      next_s.awready = 1'b1;
      next_s.wready  = 1'b1;
      next_s.bresp   = `RESP_OKAY;
      case (awaddr)
        `REG_CTRL: begin
          next_s.auto_rel = wdata[`CTRL_AUTO_REL];
          next_s.rx_en    = wdata[`CTRL_RX_EN];
        end
        `REG_MMU_CMD: begin
          case (wdata[2:0])
            `CMD_ALLOC: begin
              next_s.alloc_pend = 1'b1;
              next_s.alloc_done = 1'b0;
            end
            `CMD_RELEASE: begin
              if (!s.busy) begin
                next_s.busy = 1'b1;
                next_s.rel_pend = 1'b1;
                next_s.rel_pn = s.pns;
              end
            end
            `CMD_ENQUEUE: begin
              t_push = 1'b1;
              next_s.tx_halt = grant_dma && dma_op == DOP_TXFAIL;
            end
            `CMD_RX_REM: begin
              if (!s.busy && s.rxn != '0) begin
                r_pop = 1'b1;
                next_s.busy = 1'b1;
                next_s.rel_pend = 1'b1;
                next_s.rel_pn = s.rxq[0];
              end
            end
            `CMD_TX_ACK: c_pop = s.cn != '0;
            default: next_s.bresp = `RESP_SLVERR;
          endcase
        end
        `REG_PNS:     next_s.pns = wdata[PW-1:0];
        `REG_RESERVE: next_s.reserve = wdata[PW:0];
        `REG_PTR: begin
          next_s.ptr     = wdata[OW-1:0];
          next_s.fptr    = wdata[OW-1:0];
          next_s.rd_mode = 1'b1;
        end
        `REG_DATA, `REG_DATAB: begin
          wpush = wr_k;
          next_s.rd_mode = 1'b0;
        end
        `REG_STATUS, `REG_ALLOC, `REG_QPORT, `REG_FREE: next_s.bresp = `RESP_OKAY;
        default: next_s.bresp = `RESP_SLVERR;
      endcase
    end
    // Read channel
    if (s.arready) begin
      next_s.arready = 1'b0;
      next_s.rvalid  = 1'b1;
    end
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (rstep) begin
      next_s.arready = 1'b1;
      next_s.rresp   = `RESP_OKAY;
      case (araddr)
        `REG_CTRL: begin
          rv[`CTRL_AUTO_REL] = s.auto_rel;
          rv[`CTRL_RX_EN]    = s.rx_en;
        end
        `REG_STATUS:  rv = status_word;
        `REG_MMU_CMD: rv[`CMD_BUSY] = s.busy;
        `REG_PNS:     rv[PW-1:0] = s.pns;
        `REG_ALLOC: begin
          rv[PW-1:0]      = s.alloc_pn;
          rv[`ALLOC_DONE] = ~s.alloc_done;
        end
        `REG_QPORT: begin
          rv[PW-1:0]              = s.cq[0];
          rv[`QP_CEMPTY]          = s.cn == '0;
          rv[`QP_RXPN +: PW]      = s.rxq[0];
          rv[`QP_REMPTY]          = s.rxn == '0;
        end
        `REG_PTR:     rv[OW-1:0] = s.ptr;
        `REG_RESERVE: rv[PW:0] = s.reserve;
        `REG_FREE:    rv[PW:0] = free_cnt;
        `REG_DATA, `REG_DATAB: begin
          if (s.rd_mode) begin
            rpop = rd_k;
            rv[7:0] = s.rf[0];
            if (rd_k == 3'd2) begin
              rv[15:8] = s.rf[1];
            end
          end else begin
            next_s.rresp = `RESP_SLVERR;
          end
        end
        default: next_s.rresp = `RESP_SLVERR;
      endcase
      next_s.rdata = rv;
    end
    // Queues and byte FIFOs, each updated once per cycle
    next_s.txq = qnext(s.txq, s.txn, t_pop, t_push, t_v);
    next_s.txn = s.txn + (PW+1)'(t_push) - (PW+1)'(t_pop);
    next_s.cq  = qnext(s.cq, s.cn, c_pop, c_push, c_v);
    next_s.cn  = s.cn + (PW+1)'(c_push) - (PW+1)'(c_pop);
    next_s.rxq = qnext(s.rxq, s.rxn, r_pop, r_push, r_v);
    next_s.rxn = s.rxn + (PW+1)'(r_push) - (PW+1)'(r_pop);
    next_s.wf  = bnext(s.wf, s.wn, {2'b00, h_wr}, wpush, wdata[15:0]);
    next_s.wn  = s.wn - {2'b00, h_wr} + wpush;
    next_s.rf  = bnext(s.rf, s.rn, rpop, {2'b00, s.rd_fly}, {8'h00, mem_q});
    next_s.rn  = s.rn - rpop + {2'b00, s.rd_fly};
    if (wstep && awaddr == `REG_PTR) begin
      next_s.rn = 3'd0;
    end
    next_s.tx_hv  = (next_s.txn != '0) & ~next_s.tx_halt;
    next_s.tx_hpn = next_s.txq[0];
  end

  // All state in one register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign awready       = s.awready;
  assign wready        = s.wready;
  assign bresp         = s.bresp;
  assign bvalid        = s.bvalid;
  assign arready       = s.arready;
  assign rdata         = s.rdata;
  assign rresp         = s.rresp;
  assign rvalid        = s.rvalid;
  assign dma_ack       = s.dma_ack;
  assign dma_ok        = s.dma_ok;
  assign dma_result_pn = s.dma_res;
  assign dma_rdata     = s.dma_rdata;
  assign tx_head_valid = s.tx_hv;
  assign tx_head_pn    = s.tx_hpn;

  // Checks on arbitration, manager and queue behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic cmd_al, cmd_rel, cmd_txack;
  assign cmd_al  = wstep && awaddr == `REG_MMU_CMD && wdata[2:0] == `CMD_ALLOC;
  assign cmd_txack = wstep && awaddr == `REG_MMU_CMD && wdata[2:0] == `CMD_TX_ACK;
  assign cmd_rel = wstep && awaddr == `REG_MMU_CMD && wdata[2:0] == `CMD_RELEASE && !s.busy;

  alloc_clear_a: assert property (cmd_al |=> !s.alloc_done)
    else $error("allocation flag not cleared by request");
  alloc_set_a: assert property (h_al && have_free && !cmd_al |=> s.alloc_done &&
    s.used[$past(pick)]) else $error("allocation not completed");
  busy_a: assert property (cmd_rel |=> s.busy ##[1:4] !s.busy)
    else $error("release busy bit wrong");
  dma_wait_a: assert property (dma_want && !grant_dma ##1 dma_req |-> grant_dma)
    else $error("engine waited more than one slot");
  alternate_a: assert property (host_want && grant_dma |=> (host_want |-> grant_host))
    else $error("host starved after engine grant");
  auto_rel_a: assert property (grant_dma && dma_op == DOP_TXOK && s.auto_rel &&
    s.txn != '0 && !cmd_txack |=> !s.used[$past(head_pn)] && s.cn == $past(s.cn))
    else $error("auto release mishandled");
  tx_fail_a: assert property (grant_dma && dma_op == DOP_TXFAIL |=>
    s.cn != '0 && s.tx_halt && s.txn != '0 && !tx_head_valid) else $error("fatal error not held");
  tx_empty_a: assert property ($fell(s.txn != '0) |-> status_word[`ST_TXEMPTY] &&
    $past(grant_dma)) else $error("transmit queue emptied without completion");
  reserve_a: assert property (grant_dma && dma_op == DOP_ALLOC && free_cnt < s.reserve
    |=> dma_ack && !dma_ok) else $error("allocation below reserve granted");
  rx_done_a: assert property (grant_dma && dma_op == DOP_RXDONE |=> dma_ack &&
    s.rxn != '0 && status_word[`ST_RX] == s.rx_en) else $error("receive flag not raised");
  write_behind_a: assert property (wstep && is_wdat |=> s.wn != '0 ##1 s.bvalid)
    else $error("data write not buffered");
  prefetch_a: assert property (wstep && awaddr == `REG_PTR |=> ##[1:4] s.rn != '0)
    else $error("pointer load did not prefetch");
  data_rd_a: assert property (rstep && is_rdat |-> ##[1:ACC] s.rvalid)
    else $error("data read too slow");

  alloc_c: cover property (h_al && have_free);
  contend_c: cover property (host_want && dma_want ##1 host_want && dma_want);
  tx_fail_c: cover property (grant_dma && dma_op == DOP_TXFAIL);
  odd_word_c: cover property (rstep && araddr == `REG_DATA && s.ptr[0]);
endmodule // packet_ram_arbiter_mmu_irq
`default_nettype wire

// File: bench/dma_engine_model.sv
// Engine stand-in on the arbiter's far port
// Assumes the arbiter acks each held request
`timescale 1ns/1ps
`default_nettype none
module dma_engine_model import pkt_arb_pkg::*; (
  input  wire logic       clk,
  input  wire logic       dma_ack,
  input  wire logic       dma_ok,
  input  wire logic [2:0] dma_result_pn,
  input  wire logic [7:0] dma_rdata,
  output var  logic       dma_req,
  output var  dma_op_e    dma_op,
  output var  logic [2:0] dma_pn,
  output var  logic [7:0] dma_off,
  output var  logic [7:0] dma_wdata
);
  logic       ok;
  logic [2:0] rpn;
  logic [7:0] rd;
  int         late = 0; // Acks beyond one waiting slot
  initial begin
    dma_req = 1'b0;
    dma_op = DOP_READ;
    {dma_pn, dma_off, dma_wdata} = 19'h0_0000;
  end
  // Held until ack; payload scrambled after so stale bytes never match
  task automatic go(input dma_op_e op, input logic [2:0] pn, input logic [7:0] off,
                    input logic [7:0] wd, input int lag);
    int n;
    repeat (lag + 1) @(posedge clk);
    dma_req <= 1'b1;
    dma_op <= op;
    dma_pn <= pn;
    dma_off <= off;
    dma_wdata <= wd;
    for (n = 1; n <= 20; n++) begin
      @(posedge clk);
      if (dma_ack === 1'b1) break;
    end
    if (n > 4) late++;
    ok = dma_ok;
    rpn = dma_result_pn;
    rd = dma_rdata;
    dma_req <= 1'b0;
    dma_pn <= ~pn;
    dma_off <= ~off;
    dma_wdata <= ~wd;
  endtask
endmodule // dma_engine_model
`default_nettype wire

// File: bench/packet_ram_arbiter_mmu_irq_tb.sv
// Bench: AXI4-Lite host tasks against the arbiter, engine model on far port
// Assumes default sizing, eight packets of 256 bytes
`include "pkt_arb_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module packet_ram_arbiter_mmu_irq_tb import pkt_arb_pkg::*;;
  logic        clk = 1'b0, resetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, dma_off, dma_wdata, dma_rdata;
  logic [31:0] wdata = 32'h0000_0000, rdata, rd, sv_ptr, sv_pns;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  bresp, rresp, resp;
  logic [2:0]  dma_pn, dma_result_pn, tx_head_pn, pn, epn;
  logic        awready, wready, bvalid, arready, rvalid, dma_req, dma_ack, dma_ok;
  logic        tx_head_valid;
  dma_op_e     dma_op;
  int          fails = 0, samples_checked = 0, n;
  packet_ram_arbiter_mmu_irq packet_ram_arbiter_mmu_irq_inst (.clk, .resetn, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .dma_req, .dma_op,
    .dma_pn, .dma_off, .dma_wdata, .dma_ack, .dma_ok, .dma_result_pn, .dma_rdata,
    .tx_head_valid, .tx_head_pn);
  dma_engine_model dma_engine_model_inst (.clk, .dma_ack, .dma_ok, .dma_result_pn,
    .dma_rdata, .dma_req, .dma_op, .dma_pn, .dma_off, .dma_wdata);
  always #5 clk = ~clk;
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hung;
    fails++;
    $display("Error at %0t: bus answer missing", $time);
    test_done();
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge clk);
      if (awready === 1'b1) begin
        awvalid <= 1'b0;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    resp = bresp;
    if (n == 60) hung();
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    rd = rdata;
    resp = rresp;
    if (n == 60) hung();
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rdr(a);
    ck(rd & m, e);
  endtask
  // Polls until the result word shows done; bounded like every wait
  task automatic alloc;
    wr(`REG_MMU_CMD, 32'h0000_0001);
    for (int k = 0; k < 40; k++) begin
      rdr(`REG_ALLOC);
      if (rd[31] === 1'b0) break;
    end
    if (rd[31] !== 1'b0) hung();
    pn = rd[2:0];
  endtask
  task automatic enq;
    wr(`REG_PNS, {29'h0, pn});
    wr(`REG_MMU_CMD, 32'h0000_0003);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    rc(`REG_CTRL, 32'hffff_ffff, 32'h0000_0000);
    rc(`REG_STATUS, 32'h0000_003f, 32'h0000_0004);
    rdr(8'h2C);
    ck({30'h0, resp}, {30'h0, `RESP_SLVERR});
    wr(`REG_MMU_CMD, 32'h0000_0007);
    ck({30'h0, resp}, {30'h0, `RESP_SLVERR});
    $display("Test reset and refusals done");
    alloc();
    rc(`REG_STATUS, 32'h0000_0008, 32'h0000_0008);
    wr(`REG_PNS, {29'h0, pn});
    wr(`REG_PTR, 32'h0000_0000);
    wr(`REG_DATA, 32'h0000_5aa5);
    wr(`REG_PTR, 32'h0000_0001);
    wr(`REG_DATA, 32'h0000_3cc3);
    wr(`REG_PTR, 32'h0000_0000);
    fork
      rc(`REG_DATA, 32'h0000_ffff, 32'h0000_c3a5);
      dma_engine_model_inst.go(DOP_READ, pn, 8'h01, 8'h00, 0);
    join
    ck({24'h0, dma_engine_model_inst.rd}, 32'h0000_00c3);
    rc(`REG_DATAB, 32'h0000_00ff, 32'h0000_003c);
    $display("Test host data path done");
    enq();
    rc(`REG_STATUS, 32'h0000_0004, 32'h0000_0000);
    ck({28'h0, tx_head_valid, tx_head_pn}, {29'h0000_0001, pn});
    dma_engine_model_inst.go(DOP_TXOK, pn, 8'h00, 8'h00, 2);
    rc(`REG_STATUS, 32'h0000_0006, 32'h0000_0006);
    rc(`REG_QPORT, 32'h0000_8007, {29'h0, pn});
    wr(`REG_MMU_CMD, 32'h0000_0005);
    rc(`REG_QPORT, 32'h0000_8000, 32'h0000_8000);
    wr(`REG_MMU_CMD, 32'h0000_0002);
    rdr(`REG_MMU_CMD);
    for (int k = 0; k < 20 && rd[0] !== 1'b0; k++) rdr(`REG_MMU_CMD);
    ck({31'h0, rd[0]}, 32'h0000_0000);
    $display("Test transmit completion done");
    wr(`REG_RESERVE, 32'h0000_0009);
    dma_engine_model_inst.go(DOP_ALLOC, 3'h0, 8'h00, 8'h00, 0);
    ck({31'h0, dma_engine_model_inst.ok}, 32'h0000_0000);
    wr(`REG_RESERVE, 32'h0000_0000);
    dma_engine_model_inst.go(DOP_ALLOC, 3'h0, 8'h00, 8'h00, 1);
    ck({31'h0, dma_engine_model_inst.ok}, 32'h0000_0001);
    epn = dma_engine_model_inst.rpn;
    dma_engine_model_inst.go(DOP_WRITE, epn, 8'h04, 8'h77, 0);
    dma_engine_model_inst.go(DOP_RXDONE, epn, 8'h00, 8'h00, 0);
    rc(`REG_STATUS, 32'h0000_0001, 32'h0000_0000);
    wr(`REG_CTRL, 32'h0000_0002);
    rc(`REG_STATUS, 32'h0000_0001, 32'h0000_0001);
    rc(`REG_QPORT, 32'h8007_0000, {13'h0, epn, 16'h0});
    rdr(`REG_PTR);
    sv_ptr = rd;
    rdr(`REG_PNS);
    sv_pns = rd;
    wr(`REG_PNS, {29'h0, epn});
    wr(`REG_PTR, 32'h0000_0004);
    rc(`REG_DATAB, 32'h0000_00ff, 32'h0000_0077);
    wr(`REG_PTR, sv_ptr);
    wr(`REG_PNS, sv_pns);
    rc(`REG_PTR, 32'h0000_00ff, 32'h0000_0000);
    rc(`REG_PNS, 32'h0000_0007, {29'h0, pn});
    alloc();
    ck({31'h0, pn === epn}, 32'h0000_0000);
    wr(`REG_MMU_CMD, 32'h0000_0004);
    rc(`REG_STATUS, 32'h0000_0001, 32'h0000_0000);
    $display("Test receive queue done");
    wr(`REG_CTRL, 32'h0000_0001);
    enq();
    dma_engine_model_inst.go(DOP_TXOK, pn, 8'h00, 8'h00, 1);
    rc(`REG_STATUS, 32'h0000_0006, 32'h0000_0004);
    rc(`REG_FREE, 32'h0000_000f, 32'h0000_0008);
    alloc();
    enq();
    dma_engine_model_inst.go(DOP_TXFAIL, pn, 8'h00, 8'h00, 0);
    rc(`REG_STATUS, 32'h0000_0026, 32'h0000_0022);
    ck({31'h0, tx_head_valid}, 32'h0000_0000);
    ck(dma_engine_model_inst.late, 32'h0000_0000);
    $display("Test auto release done");
    test_done();
  end
endmodule // packet_ram_arbiter_mmu_irq_tb
`default_nettype wire
